// ### verif/lcdbk_checker.sv
// Port-level assertions for the display steering and bus receiver block.
`timescale 1ns/1ps
module lcdbk_checker #(
   parameter int STRETCH_CYCLES = 16
) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_in,
   input wire logic        scl_out,
   input wire logic        scl_oe_n,
   input wire logic        sda_out,
   input wire logic        sda_oe_n,
   input wire logic        disp_on
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [8:0] hold_cnt;
   wire logic  mapped = paddr inside {8'h00, 8'h04, 8'h08};
   // Counts how long the clock line has been held, so a stuck stretch is caught.
   always_ff @(posedge ref_clk) hold_cnt <= (rst || scl_oe_n) ? 9'h000 : hold_cnt + 9'h001;
   sequence ack_low;
      !sda_oe_n [*3];
   endsequence
   pready_high_a: assert property (pready) else $error("pready dropped");
   err_flag_a: assert property (psel && penable && !mapped |-> pslverr)
      else $error("unmapped access without error");
   no_err_a: assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access flagged");
   err_data_a: assert property (psel && penable && pslverr |-> prdata == 32'h0)
      else $error("error access returned data");
   sda_low_only_a: assert property (sda_out == 1'b0) else $error("sda driven high");
   scl_low_only_a: assert property (scl_out == 1'b0) else $error("scl driven high");
   ack_stable_a: assert property (scl_in [*3] |-> $stable(sda_oe_n))
      else $error("sda moved while scl high");
   ack_hold_a: assert property ($fell(sda_oe_n) |-> ack_low)
      else $error("acknowledge too short");
   ack_bound_a: assert property ($fell(sda_oe_n) |-> ##[1:400] sda_oe_n)
      else $error("sda held too long");
   stretch_bound_a: assert property (hold_cnt <= STRETCH_CYCLES + 2)
      else $error("clock stretch too long");
   reset_idle_a: assert property ($fell(rst) |-> sda_oe_n && scl_oe_n && !disp_on)
      else $error("outputs not idle after reset");
endmodule // lcdbk_checker
bind lcdbk_top lcdbk_checker #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_chk (.*);

// ### verif/lcdbk_i2c_master.sv
// Two-wire bus master model driving the block's receive side.
`timescale 1ns/1ps
module lcdbk_i2c_master (
   input  wire logic ref_clk,
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_rel,
   output logic      sda_rel
);
   int stretch_seen;
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      stretch_seen = 0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // The wait has no limit of its own; the bench timeout ends a stuck slave.
   task automatic rise;
      scl_rel <= 1'b1;
      tick(2);
      while (scl !== 1'b1) begin
         stretch_seen++;
         tick(1);
      end
      tick(6);
   endtask
   task automatic start;
      sda_rel <= 1'b0;
      tick(8);
      scl_rel <= 1'b0;
      tick(8);
   endtask
   task automatic stop;
      sda_rel <= 1'b0;
      tick(4);
      rise();
      sda_rel <= 1'b1;
      tick(8);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_rel <= b;
      tick(4);
      rise();
      s = sda;
      scl_rel <= 1'b0;
      tick(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      acked = !s;
   endtask
endmodule // lcdbk_i2c_master

// ### verif/tb_top.sv
// Self-checking bench for the display steering and bus receiver block.
`timescale 1ns/1ps
`include "lcdbk_params.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   import lcdbk_pkg::*;
   localparam int DIV_N [4] = '{0, 8, 16, 32};
   localparam int DIV_S [4] = '{0, 4, 8, 16};
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0;
   logic [2:0]    pins = 3'h0;
   logic [1:0]    bp_index = 2'h0;
   logic [31:0]   prdata, rd;
   logic          pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n, disp_on, m_scl, m_sda;
   logic          err, v;
   logic [39:0]   disp_bits;
   logic [15:0]   acks;
   lcdbk_mode_e   drive_mode;
   lcdbk_status_s st;
   int            miscompares = 0;
   int            check_count = 0;
   int            cycles = 0;
   int            n;
   // Open-drain lines with pull-ups: low whenever any party pulls.
   wire logic     scl_w = m_scl & scl_oe_n;
   wire logic     sda_w = m_sda & sda_oe_n;
   lcdbk_top #(.DIV_NORM_1(DIV_N[1]), .DIV_NORM_2(DIV_N[2]), .DIV_NORM_3(DIV_N[3]),
      .DIV_SAVE_1(DIV_S[1]), .DIV_SAVE_2(DIV_S[2]), .DIV_SAVE_3(DIV_S[3]),
      .STRETCH_CYCLES(32)) i_dut (.*, .scl_in(scl_w), .sda_in(sda_w),
      .hw_subaddr_bit_zero(pins[0]), .hw_subaddr_bit_one(pins[1]), .hw_subaddr_bit_two(pins[2]));
   lcdbk_i2c_master i_mst (.ref_clk(ref_clk), .scl(scl_w), .sda(sda_w), .scl_rel(m_scl),
      .sda_rel(m_sda));
   always #5 ref_clk = ~ref_clk;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic status;
      apb(1'b0, `LCDBK_REG_STATUS, 32'h0);
      st = rd;
   endtask
   task automatic ram(input logic [5:0] idx, input logic [3:0] exp);
      apb(1'b1, `LCDBK_REG_CTRL, {18'h0, idx, 8'h00});
      apb(1'b0, `LCDBK_REG_RAMRD, 32'h0);
      `CHK("ram word", exp, rd[3:0])
   endtask
   task automatic send(input logic [7:0] q[$]);
      logic a;
      acks = 16'h0;
      i_mst.start();
      foreach (q[i]) begin
         i_mst.wbyte(q[i], a);
         acks = {acks[14:0], a};
      end
      i_mst.stop();
   endtask
   // Counts clock edges between two changes of the display enable output.
   task automatic half(output int c);
      logic p;
      c = 0;
      p = disp_on;
      while (disp_on === p) @(posedge ref_clk);
      p = disp_on;
      while (disp_on === p) begin
         @(posedge ref_clk);
         c++;
      end
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b1, `LCDBK_REG_STATUS, 32'hFFFF_FFFF);
      status();
      `CHK("status", 32'h0, rd)
      `CHK("mode", LCDBK_MODE_QUAD, drive_mode)
      apb(1'b0, 8'h0C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      $display("test reset done");
      send('{8'h70, 8'hC9, 8'hE0, 8'h00, 8'hC1});
      `CHK("acks", 16'h001F, acks)
      ram(6'd0, 4'h1);
      ram(6'd2, 4'h0);
      status();
      `CHK("pointer", 6'h08, st.data_ptr)
      `CHK("display", 8'h83, disp_bits[7:0])
      $display("test store done");
      pins <= 3'h1;
      send('{8'h70, 8'hE6, 8'h00, 8'hFF});
      `CHK("acks", 16'h000E, acks)
      ram(6'd2, 4'h0);
      status();
      `CHK("pointer", 6'h08, st.data_ptr)
      `CHK("subaddr", 3'h6, st.subaddr)
      pins <= 3'h0;
      send('{8'h70, 8'hE0, 8'h20, 8'hFF, 8'hFF});
      `CHK("acks", 16'h001E, acks)
      ram(6'd39, 4'h1);
      ram(6'd2, 4'h0);
      status();
      `CHK("subaddr", 3'h1, st.subaddr)
      `CHK("pointer", 6'h08, st.data_ptr)
      $display("test subaddress done");
      send('{8'h70, 8'hFA, 8'hE0, 8'h00, 8'h80});
      ram(6'd0, 4'h5);
      send('{8'h70, 8'hC8, 8'h79});
      status();
      `CHK("in bank", 1'b1, st.in_bank)
      `CHK("out bank", 1'b0, st.out_bank)
      send('{8'h70, 8'hC9, 8'h79});
      status();
      `CHK("in bank", 1'b0, st.in_bank)
      `CHK("display", 8'h01, disp_bits[7:0])
      $display("test banks done");
      for (int lp = 0; lp < 2; lp++) begin
         for (int r = 1; r < 4; r++) begin
            send('{8'h70, 8'(8'hC9 + 16 * lp), 8'(8'h70 + r)});
            half(n);
            `CHK("blink half", (lp == 1 ? DIV_S[r] : DIV_N[r]) / 2, n)
         end
      end
      $display("test blink done");
      i_mst.stretch_seen = 0;
      send('{8'h70, 8'hF0, 8'h00, 8'h00, 8'hFF});
      `CHK("acks", 16'h001F, acks)
      `CHK("stretch", 1'b1, i_mst.stretch_seen > 0)
      ram(6'd0, 4'h4);
      ram(6'd8, 4'h1);
      send('{8'h70, 8'h51});
      `CHK("display on", 1'b0, disp_on)
      $display("test power saving done");
      send('{8'h70, 8'hCA, 8'hFB, 8'hE0, 8'h00, 8'h40});
      `CHK("acks", 16'h003F, acks)
      ram(6'd0, 4'h8);
      `CHK("display", 1'b0, disp_bits[0])
      bp_index <= 2'h1;
      repeat (2) @(posedge ref_clk);
      `CHK("display", 1'b1, disp_bits[0])
      send('{8'h70, 8'h75});
      v = disp_bits[0];
      repeat (4) @(posedge ref_clk);
      `CHK("bank swap", ~v, disp_bits[0])
      `CHK("display on", 1'b1, disp_on)
      $display("test duplex done");
      send('{8'h70, 8'hCB, 8'hF0, 8'hE0, 8'h26, 8'hFF});
      `CHK("acks", 16'h003F, acks)
      `CHK("mode", LCDBK_MODE_TRIPLEX, drive_mode)
      ram(6'd39, 4'h7);
      ram(6'd0, 4'h8);
      status();
      `CHK("subaddr", 3'h1, st.subaddr)
      `CHK("pointer", 6'h01, st.data_ptr)
      $display("test cascade done");
      give_verdict();
   end
endmodule // tb_top

// ### verilog/lcdbk_blink.sv
// Blink divider that toggles the blink phase twice per blink period.
`timescale 1ns/1ps
`include "lcdbk_params.svh"
module lcdbk_blink #(
   parameter int DIV_NORM_1 = `LCDBK_DIV_NORM_1,
   parameter int DIV_NORM_2 = `LCDBK_DIV_NORM_2,
   parameter int DIV_NORM_3 = `LCDBK_DIV_NORM_3,
   parameter int DIV_SAVE_1 = `LCDBK_DIV_SAVE_1,
   parameter int DIV_SAVE_2 = `LCDBK_DIV_SAVE_2,
   parameter int DIV_SAVE_3 = `LCDBK_DIV_SAVE_3
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   lcdbk_blink_if.gen bl
);
   import lcdbk_pkg::*;

   initial begin
      if (DIV_NORM_1 < 2 || DIV_NORM_2 < 2 || DIV_NORM_3 < 2 || DIV_SAVE_1 < 2 ||
          DIV_NORM_1 > 524286 || DIV_NORM_2 > 524286 ||
          DIV_SAVE_2 < 2 || DIV_SAVE_3 < 2 || DIV_NORM_3 > 524286 || DIV_NORM_3 < DIV_SAVE_3)
         $error("lcdbk_blink: divider ratios out of range");
   end

   lcdbk_blink_s r_reg;
   lcdbk_blink_s r_next;
   logic [17:0]  half;

   // Half of the selected ratio; odd ratios lose one cycle per period.
   always_comb begin
      half = 18'h1;
      case ({bl.power_saving, bl.rate})
         3'h1: half = 18'(DIV_NORM_1 / 2);
         3'h2: half = 18'(DIV_NORM_2 / 2);
         3'h3: half = 18'(DIV_NORM_3 / 2);
         3'h5: half = 18'(DIV_SAVE_1 / 2);
         3'h6: half = 18'(DIV_SAVE_2 / 2);
         3'h7: half = 18'(DIV_SAVE_3 / 2);
         default: half = 18'h1;
      endcase
   end

   always_comb begin
      r_next = r_reg;
      if (bl.rate == 2'h0) begin
         r_next.cnt   = 18'h0;
         r_next.phase = 1'b0;
      end else if (r_reg.cnt >= half - 18'h1) begin
         r_next.cnt   = 18'h0;
         r_next.phase = ~r_reg.phase;
      end else begin
         r_next.cnt = r_reg.cnt + 18'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bl.phase = r_reg.phase;
endmodule // lcdbk_blink

// ### verilog/lcdbk_blink_if.sv
// Link between the core and its blink divider.
`timescale 1ns/1ps
interface lcdbk_blink_if;
   logic       power_saving;
   logic [1:0] rate;
   logic       phase;
   modport core (output power_saving, output rate, input phase);
   modport gen  (input power_saving, input rate, output phase);
endinterface

// ### verilog/lcdbk_params.svh
// Constants for the display write-steering and bus receiver block.
`ifndef LCDBK_PARAMS_SVH
`define LCDBK_PARAMS_SVH

`define LCDBK_RAM_DEPTH       7'h28
`define LCDBK_SLAVE_ADDR_HI   6'h1C
`define LCDBK_BYTE_LAST_BIT   4'h7
`define LCDBK_ACK_BIT         4'h8
`define LCDBK_ACK_END         4'h9
`define LCDBK_ALT_ROW         2'h2

`define LCDBK_STEP_STATIC     6'h08
`define LCDBK_STEP_DUPLEX     6'h04
`define LCDBK_STEP_TRIPLEX    6'h03
`define LCDBK_STEP_QUAD       6'h02

`define LCDBK_REG_CTRL        8'h00
`define LCDBK_REG_STATUS      8'h04
`define LCDBK_REG_RAMRD       8'h08

`define LCDBK_DIV_NORM_1      92160
`define LCDBK_DIV_NORM_2      184320
`define LCDBK_DIV_NORM_3      368640
`define LCDBK_DIV_SAVE_1      15360
`define LCDBK_DIV_SAVE_2      30720
`define LCDBK_DIV_SAVE_3      61440
`define LCDBK_STRETCH_CYCLES  16

`endif

// ### verilog/lcdbk_pkg.sv
// Types shared by the display write-steering block.
package lcdbk_pkg;

   typedef enum logic [1:0] {
      LCDBK_MODE_QUAD    = 2'h0,
      LCDBK_MODE_STATIC  = 2'h1,
      LCDBK_MODE_DUPLEX  = 2'h2,
      LCDBK_MODE_TRIPLEX = 2'h3
   } lcdbk_mode_e;

   typedef enum logic [2:0] {
      LCDBK_ST_IDLE = 3'h0,
      LCDBK_ST_ADDR = 3'h1,
      LCDBK_ST_CMD  = 3'h3,
      LCDBK_ST_DATA = 3'h2,
      LCDBK_ST_SKIP = 3'h6
   } lcdbk_state_e;

   typedef struct packed {
      logic [17:0] rsvd;
      logic [5:0]  ram_index;
      logic [6:0]  rsvd_lo;
      logic        addr_lsb;
   } lcdbk_ctrl_s;

   typedef struct packed {
      logic [2:0]   rsvd;
      logic         stretching;
      lcdbk_state_e bus_state;
      logic         blink_phase;
      logic         blink_alt;
      logic [1:0]   blink_rate;
      logic         out_bank;
      logic         in_bank;
      logic         bias_half;
      logic         disp_en;
      logic         power_saving;
      logic [1:0]   rsvd_mid;
      lcdbk_mode_e  drive_mode;
      logic         rsvd_sub;
      logic [2:0]   subaddr;
      logic [1:0]   rsvd_lo;
      logic [5:0]   data_ptr;
   } lcdbk_status_s;

   typedef struct packed {
      logic [17:0] cnt;
      logic        phase;
   } lcdbk_blink_s;

   typedef struct packed {
      lcdbk_state_e    st;
      logic            scl_q;
      logic            sda_q;
      logic [3:0]      bitcnt;
      logic [7:0]      shreg;
      logic            ack_req;
      logic            ack_drv;
      lcdbk_mode_e     mode;
      logic            lp;
      logic            en;
      logic            bias;
      logic [5:0]      dptr;
      logic [2:0]      subcnt;
      logic            ibank;
      logic            obank;
      logic            blink_alt;
      logic [1:0]      blink_rate;
      logic [39:0][3:0] ram;
      logic [7:0]      busy;
      lcdbk_ctrl_s     ctrl;
      logic [31:0]     prdata;
      logic            pslverr;
      logic [39:0]     disp_bits;
      logic            disp_on;
   } lcdbk_core_s;

endpackage

// ### verilog/lcdbk_top.sv
// Display write steering, bank selection and receive-only two-wire slave.
`timescale 1ns/1ps
`include "lcdbk_params.svh"
module lcdbk_top #(
   parameter int DIV_NORM_1     = `LCDBK_DIV_NORM_1,
   parameter int DIV_NORM_2     = `LCDBK_DIV_NORM_2,
   parameter int DIV_NORM_3     = `LCDBK_DIV_NORM_3,
   parameter int DIV_SAVE_1     = `LCDBK_DIV_SAVE_1,
   parameter int DIV_SAVE_2     = `LCDBK_DIV_SAVE_2,
   parameter int DIV_SAVE_3     = `LCDBK_DIV_SAVE_3,
   parameter int STRETCH_CYCLES = `LCDBK_STRETCH_CYCLES
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         scl_in,
   output logic              scl_out,
   output logic              scl_oe_n,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe_n,
   input  wire logic         hw_subaddr_bit_zero,
   input  wire logic         hw_subaddr_bit_one,
   input  wire logic         hw_subaddr_bit_two,
   input  wire logic [1:0]   bp_index,
   output logic [39:0]       disp_bits,
   output logic              disp_on,
   output lcdbk_pkg::lcdbk_mode_e drive_mode
);
   import lcdbk_pkg::*;

   initial begin
      if (STRETCH_CYCLES < 1 || STRETCH_CYCLES > 255)
         $error("lcdbk_top: STRETCH_CYCLES must be 1 to 255");
   end

   lcdbk_core_s   r_reg;
   lcdbk_core_s   r_next;
   lcdbk_blink_if blink_if ();

   lcdbk_blink #(
      .DIV_NORM_1 (DIV_NORM_1),
      .DIV_NORM_2 (DIV_NORM_2),
      .DIV_NORM_3 (DIV_NORM_3),
      .DIV_SAVE_1 (DIV_SAVE_1),
      .DIV_SAVE_2 (DIV_SAVE_2),
      .DIV_SAVE_3 (DIV_SAVE_3)
   ) u_blink (
      .ref_clk (ref_clk),
      .rst     (rst),
      .bl      (blink_if.gen)
   );

   assign blink_if.power_saving = r_reg.lp;
   assign blink_if.rate         = r_reg.blink_rate;

   // Pointer increment per drive mode.
   function automatic logic [5:0] step_of(input lcdbk_mode_e m);
      case (m)
         LCDBK_MODE_STATIC:  step_of = `LCDBK_STEP_STATIC;
         LCDBK_MODE_DUPLEX:  step_of = `LCDBK_STEP_DUPLEX;
         LCDBK_MODE_TRIPLEX: step_of = `LCDBK_STEP_TRIPLEX;
         default:            step_of = `LCDBK_STEP_QUAD;
      endcase
   endfunction

   // Column offset and RAM row of serial bit k, counted from the first bit received.
   function automatic logic [4:0] slot_of(input lcdbk_mode_e m, input logic [2:0] k);
      slot_of = 5'h0;
      case (m)
         LCDBK_MODE_STATIC:  slot_of = {k, 2'h0};
         LCDBK_MODE_DUPLEX:  slot_of = {1'b0, k[2:1], 1'b0, k[0]};
         LCDBK_MODE_QUAD:    slot_of = {2'h0, k[2], k[1:0]};
         default: begin
            case (k)
               3'h0: slot_of = {3'h0, 2'h0};
               3'h1: slot_of = {3'h0, 2'h1};
               3'h2: slot_of = {3'h0, 2'h2};
               3'h3: slot_of = {3'h1, 2'h0};
               3'h4: slot_of = {3'h1, 2'h1};
               3'h5: slot_of = {3'h1, 2'h2};
               3'h6: slot_of = {3'h2, 2'h0};
               default: slot_of = {3'h2, 2'h1};
            endcase
         end
      endcase
   endfunction

   // True in the modes that own an alternate RAM bank.
   function automatic logic has_bank(input lcdbk_mode_e m);
      has_bank = (m == LCDBK_MODE_STATIC) || (m == LCDBK_MODE_DUPLEX);
   endfunction

   logic [2:0]  hw_sub;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_seen;
   logic        stop_seen;
   logic        alt_blink;
   logic        swap;
   logic [1:0]  out_row;
   lcdbk_status_s status;

   assign hw_sub     = {hw_subaddr_bit_two, hw_subaddr_bit_one, hw_subaddr_bit_zero};
   assign scl_rise   = scl_in & ~r_reg.scl_q;
   assign scl_fall   = ~scl_in & r_reg.scl_q;
   assign start_seen = scl_in & r_reg.scl_q & r_reg.sda_q & ~sda_in;
   assign stop_seen  = scl_in & r_reg.scl_q & ~r_reg.sda_q & sda_in;
   assign alt_blink  = r_reg.blink_alt & has_bank(r_reg.mode);
   assign swap       = alt_blink & blink_if.phase;

   // Row shown for the current backplane.
   always_comb begin
      case (r_reg.mode)
         LCDBK_MODE_STATIC:
            out_row = (r_reg.obank ^ swap) ? `LCDBK_ALT_ROW : 2'h0;
         LCDBK_MODE_DUPLEX:
            out_row = {r_reg.obank ^ swap, bp_index[0]};
         LCDBK_MODE_TRIPLEX:
            out_row = (bp_index == 2'h3) ? 2'h2 : bp_index;
         default:
            out_row = bp_index;
      endcase
   end

   always_comb begin
      status              = '0;
      status.data_ptr     = r_reg.dptr;
      status.subaddr      = r_reg.subcnt;
      status.drive_mode   = r_reg.mode;
      status.power_saving = r_reg.lp;
      status.disp_en      = r_reg.en;
      status.bias_half    = r_reg.bias;
      status.in_bank      = r_reg.ibank;
      status.out_bank     = r_reg.obank;
      status.blink_rate   = r_reg.blink_rate;
      status.blink_alt    = r_reg.blink_alt;
      status.blink_phase  = blink_if.phase;
      status.bus_state    = r_reg.st;
      status.stretching   = (r_reg.busy != 8'h0);
   end

   always_comb begin
      logic [7:0] b;
      logic [4:0] slot;
      logic [6:0] col;
      logic [1:0] row;
      logic [2:0] sub;
      logic [6:0] np;
      b    = {r_reg.shreg[6:0], sda_in};
      slot = 5'h0;
      col  = 7'h0;
      row  = 2'h0;
      sub  = 3'h0;
      np   = 7'h0;
      r_next       = r_reg;
      r_next.scl_q = scl_in;
      r_next.sda_q = sda_in;
      if (r_reg.busy != 8'h0) begin
         r_next.busy = r_reg.busy - 8'h1;
      end

      if (start_seen) begin
         r_next.st      = LCDBK_ST_ADDR;
         r_next.bitcnt  = 4'h0;
         r_next.ack_drv = 1'b0;
      end else if (stop_seen) begin
         r_next.st      = LCDBK_ST_IDLE;
         r_next.bitcnt  = 4'h0;
         r_next.ack_drv = 1'b0;
      end else if (r_reg.st != LCDBK_ST_IDLE) begin
         if (scl_rise && r_reg.bitcnt < `LCDBK_ACK_END) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
            if (r_reg.bitcnt < `LCDBK_ACK_BIT) begin
               r_next.shreg = b;
            end
            // Whole byte in; no byte count limit within one transfer.
            if (r_reg.bitcnt == `LCDBK_BYTE_LAST_BIT) begin
               r_next.ack_req = 1'b0;
               case (r_reg.st)
                  LCDBK_ST_ADDR: begin
                     // Write-only slave; a read address is not claimed.
                     if (b == {`LCDBK_SLAVE_ADDR_HI, r_reg.ctrl.addr_lsb, 1'b0}) begin
                        r_next.ack_req = 1'b1;
                        r_next.st      = LCDBK_ST_CMD;
                     end else begin
                        r_next.st = LCDBK_ST_SKIP;
                     end
                  end
                  LCDBK_ST_CMD: begin
                     r_next.ack_req = 1'b1;
                     if (!b[7]) begin
                        r_next.st = LCDBK_ST_DATA;
                     end
                     if (!b[6]) begin
                        r_next.dptr = b[5:0];
                     end else if (!b[5]) begin
                        r_next.lp   = b[4];
                        r_next.en   = b[3];
                        r_next.bias = b[2];
                        r_next.mode = lcdbk_mode_e'(b[1:0]);
                     end else if (b[4:3] == 2'h0) begin
                        r_next.subcnt = b[2:0];
                     end else if (b[4:3] == 2'h3) begin
                        if (has_bank(r_reg.mode) && !b[2]) begin
                           r_next.ibank = b[1];
                           r_next.obank = b[0];
                        end
                     end else if (b[4:3] == 2'h2) begin
                        r_next.blink_alt  = b[2];
                        r_next.blink_rate = b[1:0];
                     end
                  end
                  LCDBK_ST_DATA: begin
                     // Only the device whose pins match answers for data.
                     r_next.ack_req = (r_reg.subcnt == hw_sub);
                     // Each bit finds its own device, so a handover inside a character works.
                     for (int k = 0; k < 8; k++) begin
                        slot = slot_of(r_reg.mode, 3'(k));
                        col  = {1'b0, r_reg.dptr} + {4'h0, slot[4:2]};
                        sub  = r_reg.subcnt;
                        if (col >= `LCDBK_RAM_DEPTH) begin
                           col = col - `LCDBK_RAM_DEPTH;
                           sub = r_reg.subcnt + 3'h1;
                        end
                        row = slot[1:0];
                        if (r_reg.ibank && has_bank(r_reg.mode)) begin
                           row = row + `LCDBK_ALT_ROW;
                        end
                        if (sub == hw_sub) begin
                           r_next.ram[col[5:0]][row] = b[7 - k];
                        end
                     end
                     np = {1'b0, r_reg.dptr} + {1'b0, step_of(r_reg.mode)};
                     if (np >= `LCDBK_RAM_DEPTH) begin
                        np            = np - `LCDBK_RAM_DEPTH;
                        r_next.subcnt = r_reg.subcnt + 3'h1;
                     end
                     r_next.dptr = np[5:0];
                     // RAM updates are slower when power saving, so hold the clock.
                     if (r_reg.lp) begin
                        r_next.busy = 8'(STRETCH_CYCLES);
                     end
                  end
                  default: r_next.st = LCDBK_ST_SKIP;
               endcase
            end
         end
         if (scl_fall) begin
            if (r_reg.bitcnt == `LCDBK_ACK_BIT) begin
               r_next.ack_drv = r_reg.ack_req;
            end else if (r_reg.bitcnt == `LCDBK_ACK_END) begin
               r_next.ack_drv = 1'b0;
               r_next.bitcnt  = 4'h0;
            end
         end
      end

      // Register bus: read data is latched in setup so access needs no wait.
      if (psel && !penable) begin
         r_next.pslverr = 1'b0;
         if (paddr == `LCDBK_REG_CTRL) begin
            r_next.prdata = r_reg.ctrl;
         end else if (paddr == `LCDBK_REG_STATUS) begin
            r_next.prdata = status;
         end else if (paddr == `LCDBK_REG_RAMRD) begin
            r_next.prdata = {28'h0, r_reg.ram[r_reg.ctrl.ram_index]};
         end else begin
            r_next.prdata  = 32'h0;
            r_next.pslverr = 1'b1;
         end
      end
      if (psel && penable && pwrite && paddr == `LCDBK_REG_CTRL) begin
         r_next.ctrl.addr_lsb  = pwdata[0];
         r_next.ctrl.ram_index = (pwdata[13:8] >= 6'(`LCDBK_RAM_DEPTH)) ? 6'h0 : pwdata[13:8];
      end

      for (int c = 0; c < int'(`LCDBK_RAM_DEPTH); c++) begin
         r_next.disp_bits[c] = r_reg.ram[c][out_row];
      end
      // Normal blinking blanks the whole display; bank blinking only swaps banks.
      r_next.disp_on = r_reg.en & ~((r_reg.blink_rate != 2'h0) & ~alt_blink & blink_if.phase);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r_reg       <= '0;
         r_reg.scl_q <= 1'b1;
         r_reg.sda_q <= 1'b1;
         r_reg.mode  <= LCDBK_MODE_QUAD;
         r_reg.st    <= LCDBK_ST_IDLE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata     = r_reg.prdata;
   assign pready     = 1'b1;
   assign pslverr    = r_reg.pslverr & psel & penable;
   assign sda_out    = 1'b0;
   assign sda_oe_n   = ~r_reg.ack_drv;
   assign scl_out    = 1'b0;
   // Only grab SCL once it is already low so a high phase is never cut short.
   assign scl_oe_n   = ~((r_reg.busy != 8'h0) & ~scl_in & ~r_reg.scl_q);
   assign disp_bits  = r_reg.disp_bits;
   assign disp_on    = r_reg.disp_on;
   assign drive_mode = r_reg.mode;
endmodule // lcdbk_top
